// ===== hdl/scc_checker.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module scc_checker import scc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_err_i,
  input wire scc_bus_t bus_i,
  output logic [31:0] bus_rdata_o,
  output logic resp_valid_o,
  output scc_resp_t resp_o,
  output logic [31:0] setup_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // character helpers
  // ----------------------------------------------------------------
  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic is_lc_hex(input logic [7:0] c);
    is_lc_hex = (c >= 8'h61 && c <= 8'h66);
  endfunction

  // nibble value; upper case letters have low nibble 1..6
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scc_state_t state_reg;
  logic [7:0] char_reg [SCC_BUF_DEPTH];
  logic [4:0] len_reg;
  logic ovf_reg;
  logic perr_reg;
  logic [7:0] sum_reg;
  logic [31:0] setup_reg;
  logic wen_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic resp_valid_reg;
  scc_resp_t resp_reg;

  logic rx_cr;
  logic frame_end;
  logic par_en;

  assign rx_cr = rx_valid_i && (rx_data_i == SCC_CHR_CR);
  assign frame_end = (state_reg == SCC_ST_BODY) && rx_cr;
  assign par_en = setup_reg[SCC_PAR_EN_BIT];

  // ----------------------------------------------------------------
  // frame parser
  // ----------------------------------------------------------------
  // prompt, address match, then body up to carriage return
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= SCC_ST_IDLE;
    end else if (rx_valid_i) begin
      unique case (state_reg)
        SCC_ST_IDLE: begin
          if (rx_data_i == SCC_CHR_DOLLAR || rx_data_i == SCC_CHR_HASH) begin
            state_reg <= SCC_ST_ADDR;
          end
        end
        SCC_ST_ADDR: begin
          if (rx_data_i == setup_reg[SCC_ADDR_LSB +: 8]) begin
            state_reg <= SCC_ST_BODY;
          end else if (rx_cr) begin
            state_reg <= SCC_ST_IDLE;
          end else begin
            state_reg <= SCC_ST_SKIP;
          end
        end
        SCC_ST_BODY: begin
          if (rx_cr) begin
            state_reg <= SCC_ST_IDLE;
          end
        end
        SCC_ST_SKIP: begin
          if (rx_cr) begin
            state_reg <= SCC_ST_IDLE;
          end
        end
      endcase
    end
  end

  // body character store and length count
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      len_reg <= 5'h00;
      ovf_reg <= 1'b0;
      for (int i = 0; i < SCC_BUF_DEPTH; i++) begin
        char_reg[i] <= 8'h00;
      end
    end else if (rx_valid_i && state_reg == SCC_ST_ADDR) begin
      len_reg <= 5'h00;
      ovf_reg <= 1'b0;
    end else if (rx_valid_i && state_reg == SCC_ST_BODY && !rx_cr) begin
      if (len_reg < 5'(SCC_BUF_DEPTH)) begin
        char_reg[len_reg[3:0]] <= rx_data_i;
        len_reg <= len_reg + 5'h01;
      end else begin
        ovf_reg <= 1'b1; // too many characters
      end
    end
  end

  // running sum of prompt, address and body
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sum_reg <= 8'h00;
    end else if (rx_valid_i && !rx_cr) begin
      if (state_reg == SCC_ST_IDLE) begin
        sum_reg <= rx_data_i;
      end else begin
        sum_reg <= sum_reg + rx_data_i;
      end
    end
  end

  // sticky parity fault over the frame
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      perr_reg <= 1'b0;
    end else if (rx_valid_i && state_reg == SCC_ST_IDLE) begin
      perr_reg <= rx_parity_err_i;
    end else if (rx_valid_i) begin
      perr_reg <= perr_reg || rx_parity_err_i;
    end
  end

  // ----------------------------------------------------------------
  // command evaluation at frame end
  // ----------------------------------------------------------------
  logic cmd_we;
  logic cmd_su;
  logic cmd_rs;
  logic rs_alias;
  logic [4:0] op_base;
  logic [4:0] op_len;
  logic [7:0] cks_hi;
  logic [7:0] cks_lo;
  logic cks_here;
  logic [7:0] cks_sum;
  logic len_bad;
  logic su_syn;
  logic su_val;
  logic [31:0] su_data;
  logic addr_bad;
  scc_rsp_t rsp_kind;

  always_comb begin
    cmd_we = (char_reg[0] == SCC_CHR_W) && (char_reg[1] == SCC_CHR_E);
    cmd_su = (char_reg[0] == SCC_CHR_S) && (char_reg[1] == SCC_CHR_U);
    cmd_rs = (char_reg[0] == SCC_CHR_R) && (char_reg[1] == SCC_CHR_S);
    // readback also accepted with a trailing U
    rs_alias = cmd_rs && (len_reg >= 5'h03) && (char_reg[2] == SCC_CHR_U);
    op_base = rs_alias ? 5'h03 : 5'h02;
    op_len = (len_reg >= op_base) ? len_reg - op_base : 5'h00;
    cks_hi = char_reg[4'(len_reg - 5'h02)];
    cks_lo = char_reg[4'(len_reg - 5'h01)];
    // two hex characters beyond the operand are the checksum
    cks_here = ((cmd_su && op_len == SCC_OPND_CKS_LEN) ||
                ((cmd_we || cmd_rs) && op_len == SCC_CKS_LEN)) &&
               is_hex(cks_hi) && is_hex(cks_lo);
    cks_sum = sum_reg - cks_hi - cks_lo;
    len_bad = ovf_reg || (len_reg < 5'h02) ||
              (cmd_su && op_len != SCC_OPND_LEN && op_len != SCC_OPND_CKS_LEN) ||
              (cmd_su && op_len == SCC_OPND_CKS_LEN && !cks_here) ||
              ((cmd_we || cmd_rs) && op_len != 5'h00 && !cks_here);
    su_syn = 1'b0;
    su_val = 1'b0;
    su_data = 32'h0;
    for (int k = 0; k < 8; k++) begin
      // lower case hex is out of digit range, other junk aborts
      if (is_lc_hex(char_reg[2 + k])) begin
        su_val = 1'b1;
      end else if (!is_hex(char_reg[2 + k])) begin
        su_syn = 1'b1;
      end
      su_data[31 - 4 * k -: 4] = hex_val(char_reg[2 + k]);
    end
    addr_bad = su_data[31] ||
               su_data[31:24] == SCC_CHR_NUL || su_data[31:24] == SCC_CHR_CR ||
               su_data[31:24] == SCC_CHR_DOLLAR || su_data[31:24] == SCC_CHR_HASH ||
               su_data[31:24] == SCC_CHR_LBRACE || su_data[31:24] == SCC_CHR_RBRACE;
    // error priority: first matching wins
    if (par_en && perr_reg) begin
      rsp_kind = SCC_RSP_PAR;
    end else if (cks_here && cks_sum != {hex_val(cks_hi), hex_val(cks_lo)}) begin
      rsp_kind = SCC_RSP_CKS;
    end else if (len_reg >= 5'h02 && !(cmd_we || cmd_su || cmd_rs)) begin
      rsp_kind = SCC_RSP_CMD;
    end else if (len_bad || (cmd_su && su_syn)) begin
      rsp_kind = SCC_RSP_SYN;
    end else if (cmd_su && su_val) begin
      rsp_kind = SCC_RSP_VAL;
    end else if (cmd_su && !wen_reg) begin
      rsp_kind = SCC_RSP_WP;
    end else if (cmd_su && addr_bad) begin
      rsp_kind = SCC_RSP_ADDR;
    end else begin
      rsp_kind = SCC_RSP_OK;
    end
  end

  // ----------------------------------------------------------------
  // setup store and write unlock
  // ----------------------------------------------------------------
  // setup store, only a clean unlocked write changes it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      setup_reg <= SCC_SETUP_RST;
    end else if (frame_end && cmd_su && rsp_kind == SCC_RSP_OK) begin
      setup_reg <= su_data;
    end
  end

  // unlock survives other errors, dropped by any success but a write unlock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wen_reg <= 1'b0;
    end else if (frame_end) begin
      if (rsp_kind == SCC_RSP_OK) begin
        wen_reg <= cmd_we;
      end else if (rsp_kind == SCC_RSP_WP) begin
        wen_reg <= 1'b0;
      end
    end
  end

  // answer carries the address in force when the frame arrived
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      resp_valid_reg <= 1'b0;
      resp_reg <= '{kind: SCC_RSP_OK, addr: 8'h00, data: 32'h0};
    end else begin
      resp_valid_reg <= frame_end;
      if (frame_end) begin
        resp_reg.kind <= rsp_kind;
        resp_reg.addr <= setup_reg[SCC_ADDR_LSB +: 8];
        resp_reg.data <= (cmd_rs && rsp_kind == SCC_RSP_OK) ? setup_reg : 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  // sticky answer events; a new event beats a clear
  always_comb begin
    status_next = status_reg;
    if (bus_i.wr && bus_i.addr == SCC_OFS_STATUS) begin
      status_next = status_reg & ~bus_i.wdata[7:0];
    end
    if (frame_end) begin
      status_next[rsp_kind] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_reg <= SCC_MASK_RST;
    end else if (bus_i.wr && bus_i.addr == SCC_OFS_MASK) begin
      mask_reg <= bus_i.wdata[7:0];
    end
  end

  // read data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        SCC_OFS_STATUS: rdata_reg <= {24'h0, status_reg};
        SCC_OFS_MASK: rdata_reg <= {24'h0, mask_reg};
        SCC_OFS_SETUP: rdata_reg <= setup_reg;
        SCC_OFS_CTRL: rdata_reg <= {29'h0, state_reg != SCC_ST_IDLE, perr_reg, wen_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign resp_valid_o = resp_valid_reg;
  assign resp_o = resp_reg;
  assign setup_o = setup_reg;
  assign irq_o = irq_reg;

endmodule

// ===== hdl/scc_pkg.sv
// Summary of operation
// - two trailing hex characters form a checksum
// - checksum mismatch aborts with checksum error
// - unknown or lowercase commands give command error
// - parity error only while parity checking enabled
// - wrong length or layout gives syntax error
// - bad digit in field gives value error
// - setup write needs preceding write unlock
// - good setup write stores thirty-two bits
// - setup operand exactly eight hex characters
// - bit seven is each byte's top bit
// - non-hex character aborts setup, syntax error
// - byte one becomes the answering address
// - old address ignored after address change
// - address byte with top bit set rejected
// - reserved address codes give address error
// - readback command returns stored setup
// - successful protected command drops write unlock
// - errors carry address, abort the command
package scc_pkg;

  // ----------------------------------------------------------------
  // characters
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_CHR_DOLLAR = 8'h24;
  localparam logic [7:0] SCC_CHR_HASH = 8'h23;
  localparam logic [7:0] SCC_CHR_CR = 8'h0d;
  localparam logic [7:0] SCC_CHR_NUL = 8'h00;
  localparam logic [7:0] SCC_CHR_LBRACE = 8'h7b;
  localparam logic [7:0] SCC_CHR_RBRACE = 8'h7d;
  localparam logic [7:0] SCC_CHR_W = 8'h57;
  localparam logic [7:0] SCC_CHR_E = 8'h45;
  localparam logic [7:0] SCC_CHR_S = 8'h53;
  localparam logic [7:0] SCC_CHR_U = 8'h55;
  localparam logic [7:0] SCC_CHR_R = 8'h52;

  // ----------------------------------------------------------------
  // frame layout and setup fields
  // ----------------------------------------------------------------
  localparam int SCC_BUF_DEPTH = 16;
  localparam logic [4:0] SCC_OPND_LEN = 5'h08;
  localparam logic [4:0] SCC_CKS_LEN = 5'h02;
  localparam logic [4:0] SCC_OPND_CKS_LEN = 5'h0a;
  localparam int SCC_ADDR_LSB = 24;
  localparam int SCC_PAR_EN_BIT = 21;
  localparam logic [31:0] SCC_SETUP_RST = 32'h31070000;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_OFS_STATUS = 8'h00;
  localparam logic [7:0] SCC_OFS_MASK = 8'h04;
  localparam logic [7:0] SCC_OFS_SETUP = 8'h08;
  localparam logic [7:0] SCC_OFS_CTRL = 8'h0c;
  localparam logic [7:0] SCC_MASK_RST = 8'h00;

  // answer kinds, also the status bit index
  typedef enum logic [2:0] {
    SCC_RSP_OK = 3'h0,
    SCC_RSP_ADDR = 3'h1,
    SCC_RSP_CKS = 3'h2,
    SCC_RSP_CMD = 3'h3,
    SCC_RSP_PAR = 3'h4,
    SCC_RSP_SYN = 3'h5,
    SCC_RSP_VAL = 3'h6,
    SCC_RSP_WP = 3'h7
  } scc_rsp_t;

  // parser states, gray along idle-addr-body
  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'b00,
    SCC_ST_ADDR = 2'b01,
    SCC_ST_BODY = 2'b11,
    SCC_ST_SKIP = 2'b10
  } scc_state_t;

  // answer handed to the transmit side
  typedef struct packed {
    scc_rsp_t kind;
    logic [7:0] addr;
    logic [31:0] data;
  } scc_resp_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scc_bus_t;

endpackage

// ===== dv/scc_checker_asserts.sv
`timescale 1ns/10ps
module scc_checker_asserts import scc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_err_i,
  input wire scc_bus_t bus_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic resp_valid_o,
  input wire scc_resp_t resp_o,
  input wire logic [31:0] setup_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // answers
  // ----------------------------------------
  AST_RESP_AFTER_CR: assert property (resp_valid_o |-> $past(rx_valid_i && rx_data_i == SCC_CHR_CR))
    else $error("answer without closing character");
  AST_RESP_ADDR: assert property (resp_valid_o |-> resp_o.addr == $past(setup_o[31:24]))
    else $error("answer carries wrong address");
  AST_RESP_PULSE: assert property (resp_valid_o |=> !resp_valid_o)
    else $error("answer pulse too long");
  AST_ERR_NO_DATA: assert property (resp_valid_o && resp_o.kind != SCC_RSP_OK |-> resp_o.data == 32'h0)
    else $error("error answer carries data");
  AST_PAR_ONLY_ON: assert property (resp_valid_o && resp_o.kind == SCC_RSP_PAR |-> setup_o[SCC_PAR_EN_BIT])
    else $error("parity error while parity off");
  // ----------------------------------------
  // stored setup
  // ----------------------------------------
  AST_SETUP_ONLY_OK: assert property ($changed(setup_o) |-> resp_valid_o && resp_o.kind == SCC_RSP_OK)
    else $error("setup changed without good answer");
  AST_ADDR_TOP: assert property (setup_o[31] == 1'b0)
    else $error("address top bit set");
  AST_ADDR_LEGAL: assert property (!(setup_o[31:24] inside {8'h00, 8'h0d, 8'h23, 8'h24, 8'h7b, 8'h7d}))
    else $error("reserved address stored");
  // ----------------------------------------
  // register port
  // ----------------------------------------
  AST_RDATA_IDLE: assert property (!$past(bus_i.rd) |-> bus_rdata_o == 32'h0)
    else $error("read data outside read slot");
  AST_RDATA_SETUP: assert property ($past(bus_i.rd && bus_i.addr == SCC_OFS_SETUP) |-> bus_rdata_o == $past(setup_o))
    else $error("setup read mismatch");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> resp_valid_o || $past(bus_i.wr, 2))
    else $error("interrupt without cause");
endmodule
bind scc_checker scc_checker_asserts u_scc_checker_asserts (.core_clk_i, .rst_i, .rx_valid_i, .rx_data_i,
  .rx_parity_err_i, .bus_i, .bus_rdata_o, .resp_valid_o, .resp_o, .setup_o, .irq_o);

// ===== dv/scc_host_model.sv
`timescale 1ns/10ps
module scc_host_model (
  input wire logic core_clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_parity_err_o
);
  bit busy;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_parity_err_o = 1'b0;
  end
  // idle data line keeps changing
  always @(posedge core_clk_i) begin
    if (!busy) begin
      rx_data_o <= ~rx_data_o;
    end
  end
  // one frame, one character a cycle, closing cr
  task automatic send(input string s, input bit pe);
    busy = 1'b1;
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= (i == s.len()) ? 8'h0d : s[i];
      rx_parity_err_o <= pe && (i == 1);
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_parity_err_o <= 1'b0;
    busy <= 1'b0;
  endtask
endmodule

// ===== dv/tb_scc_checker.sv
`timescale 1ns/10ps
module tb_scc_checker import scc_pkg::*;;
  typedef struct {
    string c;
    bit [1:0] ck;
    bit pe;
    bit q;
    scc_rsp_t k;
    logic [31:0] su;
  } scc_row_t;
  logic core_clk_i;
  logic rst_i;
  logic rx_valid_i;
  logic [7:0] rx_data_i;
  logic rx_parity_err_i;
  scc_bus_t bus_i;
  logic [31:0] bus_rdata_o;
  logic resp_valid_o;
  scc_resp_t resp_o;
  logic [31:0] setup_o;
  logic irq_o;
  int n_errors;
  int cmp_count;
  logic [31:0] cur;
  bit got;
  // frame, checksum none/good/bad, parity fault, silent, answer, setup after
  scc_row_t rows[16] = '{
    '{"$1RS", 0, 1, 0, SCC_RSP_OK, 32'h31070000},
    '{"$1SU31070102", 0, 0, 0, SCC_RSP_WP, 32'h31070000},
    '{"$1WE", 0, 0, 0, SCC_RSP_OK, 32'h31070000},
    '{"$1we", 0, 0, 0, SCC_RSP_CMD, 32'h31070000},
    '{"$1SU3107010", 0, 0, 0, SCC_RSP_SYN, 32'h31070000},
    '{"$1SU310701X2", 0, 0, 0, SCC_RSP_SYN, 32'h31070000},
    '{"$1SU3107010a", 0, 0, 0, SCC_RSP_VAL, 32'h31070000},
    '{"$1SU7B070102", 0, 0, 0, SCC_RSP_ADDR, 32'h31070000},
    '{"$1SUB1070102", 0, 0, 0, SCC_RSP_ADDR, 32'h31070000},
    '{"$1SU32270102", 2, 0, 0, SCC_RSP_CKS, 32'h31070000},
    '{"$1SU32270102", 1, 0, 0, SCC_RSP_OK, 32'h32270102},
    '{"$1RS", 0, 0, 1, SCC_RSP_OK, 32'h32270102},
    '{"$2SU31070000", 0, 0, 0, SCC_RSP_WP, 32'h32270102},
    '{"#2RS", 1, 0, 0, SCC_RSP_OK, 32'h32270102},
    '{"$2RSU", 0, 0, 0, SCC_RSP_OK, 32'h32270102},
    '{"$2RS", 0, 1, 0, SCC_RSP_PAR, 32'h32270102}
  };
  scc_host_model u_scc_host_model (.core_clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .rx_parity_err_o(rx_parity_err_i));
  scc_checker u_scc_checker (.core_clk_i, .rst_i, .rx_valid_i, .rx_data_i, .rx_parity_err_i, .bus_i,
    .bus_rdata_o, .resp_valid_o, .resp_o, .setup_o, .irq_o);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic byte hx(input logic [3:0] n);
    return (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // frame text with optional checksum pair
  function automatic string mk(input scc_row_t r);
    byte s;
    s = 0;
    for (int i = 0; i < r.c.len(); i++) s += r.c[i];
    if (r.ck == 2) s++;
    return r.ck ? $sformatf("%s%c%c", r.c, hx(s[7:4]), hx(s[3:0])) : r.c;
  endfunction
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    bus_i <= '0;
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    bus_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1;
    chk("rdata", e, bus_rdata_o);
  endtask
  task automatic run(input scc_row_t r);
    got = 0;
    u_scc_host_model.send(mk(r), r.pe);
    // answer pulse stands only in the cycle right after the closing edge
    #1;
    got = resp_valid_o;
    repeat (3) begin
      @(posedge core_clk_i);
      #1;
      got |= resp_valid_o;
    end
    chk("answer", !r.q, got);
    if (got) begin
      chk("kind", r.k, resp_o.kind);
      chk("addr", cur[31:24], resp_o.addr);
      chk("data", (r.k == SCC_RSP_OK && r.c[2] == "R") ? r.su : 32'h0, resp_o.data);
    end
    chk("setup", r.su, setup_o);
    cur = r.su;
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100us;
    n_errors++;
    give_verdict;
  end
  initial begin
    rst_i = 1'b1;
    bus_i = '0;
    cur = SCC_SETUP_RST;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("setup", SCC_SETUP_RST, setup_o);
    foreach (rows[i]) run(rows[i]);
    chk("irq", 0, irq_o);
    bw(SCC_OFS_MASK, 32'hff);
    br(SCC_OFS_MASK, 32'hff);
    chk("irq", 1, irq_o);
    br(SCC_OFS_STATUS, 32'hff);
    bw(SCC_OFS_STATUS, 32'hff);
    br(SCC_OFS_STATUS, 32'h0);
    chk("irq", 0, irq_o);
    bw(SCC_OFS_SETUP, 32'h0);
    br(SCC_OFS_SETUP, 32'h32270102);
    br(8'h10, 32'h0);
    // idle, parity fault of last frame seen, unlock dropped
    br(SCC_OFS_CTRL, 32'h2);
    // second reset in mid-run
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cur = SCC_SETUP_RST;
    run('{"$1RS", 0, 0, 0, SCC_RSP_OK, SCC_SETUP_RST});
    // status clear in the very cycle of a new answer: the event wins
    fork
      u_scc_host_model.send("$1RS", 1'b0);
      begin
        repeat (4) @(posedge core_clk_i);
        bw(SCC_OFS_STATUS, 32'hff);
      end
    join
    br(SCC_OFS_STATUS, 32'h1);
    give_verdict;
  end
endmodule
